// ### logic/isq_core.sv
// instruction sequencer: phase generator, prefetch pipeline, program
// counter, return stack and 8-bit alu, with a wishbone register port.
// assumes program memory answers combinationally in the fetch phase.
//
// Overview of operation
// (RULE1) four non-overlapping phases from the clock form one instruction cycle
// (RULE2) counter advances and next word is fetched in the first phase
// (RULE3) phases two to four decode and execute the earlier fetched word
// (RULE4) fetch overlaps execution, one ordinary instruction per cycle
// (RULE5) branch and call take two cycles, prefetched word discarded
// (RULE6) without branching the counter grows by exactly one per instruction
// (RULE7) counter is 11 bits, only low byte reachable by software
// (RULE8) branch, call, interrupt and reset load the target directly
// (RULE9) a met skip condition replaces the prefetched word by a dummy cycle
// (RULE10) low byte read and write, write keeps page bits, 256-word page
// (RULE11) a low byte write inserts one dummy cycle for the new prefetch
// (RULE12) return stack holds counter values, no software access
// (RULE13) call or interrupt acknowledge pushes the counter
// (RULE14) subroutine or interrupt return pops the stack into the counter
// (RULE15) reset leaves the stack pointer at the empty top
// (RULE16) full stack: request latched, acknowledge held until a return
// (RULE17) call on full stack still runs, oldest entry is lost
// (RULE18) 8-bit alu writes result and updates carry and other flags
// (RULE19) add, subtract, adjust, logic, rotate, step and branch decisions
// (RULE20) after reset execution starts at address zero
// (RULE21) stack depth is a parameter, full and empty follow from it
`timescale 1ns/100ps
module isq_core #(
   parameter int STACK_DEPTH = 4
) (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   output logic [10:0] mem_addr_out,
   output logic mem_rd_out,
   input wire logic [14:0] mem_data_in,
   input wire logic irq_in,
   output logic int_ack_out,
   output logic [3:0] phase_out,
   output logic stack_full_out
);
   localparam int SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;
   localparam int CNT_W = $clog2(STACK_DEPTH + 1);
   localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(STACK_DEPTH);
   localparam logic [SP_W-1:0] PTR_LAST = SP_W'(STACK_DEPTH - 1);

   localparam logic [14:0] DUMMY_WORD = {isq_pkg::OP_NOP, 12'h000};

   // sequencing state
   isq_pkg::isq_phase_t phase;
   logic [10:0] pc;
   logic [14:0] fetch_ir;
   logic [14:0] exec_ir;
   logic kill;
   logic run;
   logic irq_pending;
   logic [7:0] acc;
   logic [3:0] flags;

   // return stack
   logic [10:0] stack_mem [STACK_DEPTH];
   logic [SP_W-1:0] sp;
   logic [CNT_W-1:0] cnt;
   logic [SP_W-1:0] sp_below;
   logic [10:0] stack_top;
   logic [10:0] push_val;
   logic stack_full;
   logic stack_empty;

   // decode of the executing word
   logic t1;
   logic t4;
   logic [2:0] op_class;
   logic [3:0] op_fn;
   logic [7:0] op_imm;
   logic [10:0] op_target;
   logic skip_hit;
   logic [7:0] step_val;
   logic do_alu;
   logic do_movi;
   logic do_branch;
   logic do_call;
   logic do_return;
   logic do_skip;
   logic do_pcl_op;
   logic irq_take;
   logic push;
   logic flow_change;

   // register port
   logic bus_req;
   logic bus_wr;
   logic pcl_wr;
   logic ctl_wr;
   logic [31:0] rd_mux;

   // page-local jump: only the low byte is replaced
   function automatic logic [10:0] page_jump(
      input logic [10:0] cur,
      input logic [7:0] low
   );
      page_jump = {cur[10:8], low};
   endfunction

   // 8-bit alu, returns {flags, result}; carry set means no borrow
   function automatic logic [11:0] alu_calc(
      input logic [3:0] fn,
      input logic [7:0] a,
      input logic [7:0] b,
      input logic [3:0] fl
   );
      logic [8:0] wide;
      logic [4:0] half;
      logic [7:0] res;
      logic [3:0] nf;
      logic cin;
      cin = fl[isq_pkg::FLAG_C];
      wide = 9'h000;
      half = 5'h00;
      res = a;
      nf = fl;
      case (fn)
         isq_pkg::ALU_ADD, isq_pkg::ALU_ADC: begin
            wide = {1'b0, a} + {1'b0, b} + {8'h00, cin & (fn == isq_pkg::ALU_ADC)};
            half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin & (fn == isq_pkg::ALU_ADC)};
            res = wide[7:0];
            nf[isq_pkg::FLAG_C] = wide[8];
            nf[isq_pkg::FLAG_AC] = half[4];
            nf[isq_pkg::FLAG_OV] = (a[7] == b[7]) && (res[7] != a[7]);
         end
         isq_pkg::ALU_SUB, isq_pkg::ALU_SBC: begin
            wide = {1'b0, a} + {1'b0, ~b} + {8'h00, cin | (fn == isq_pkg::ALU_SUB)};
            half = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin | (fn == isq_pkg::ALU_SUB)};
            res = wide[7:0];
            nf[isq_pkg::FLAG_C] = wide[8];
            nf[isq_pkg::FLAG_AC] = half[4];
            nf[isq_pkg::FLAG_OV] = (a[7] != b[7]) && (res[7] != a[7]);
         end
         isq_pkg::ALU_DADJ: begin
            wide = {1'b0, a};
            if (a[3:0] > 4'h9 || fl[isq_pkg::FLAG_AC]) begin
               wide = wide + 9'h006;
            end
            if (wide[8:4] > 5'h09 || cin) begin
               wide = wide + 9'h060;
            end
            res = wide[7:0];
            nf[isq_pkg::FLAG_C] = cin | wide[8];
         end
         isq_pkg::ALU_AND: begin
            res = a & b;
         end
         isq_pkg::ALU_OR: begin
            res = a | b;
         end
         isq_pkg::ALU_XOR: begin
            res = a ^ b;
         end
         isq_pkg::ALU_CPL: begin
            res = ~a;
         end
         isq_pkg::ALU_RR: begin
            res = {a[0], a[7:1]};
         end
         isq_pkg::ALU_RRC: begin
            res = {cin, a[7:1]};
            nf[isq_pkg::FLAG_C] = a[0];
         end
         isq_pkg::ALU_RL: begin
            res = {a[6:0], a[7]};
         end
         isq_pkg::ALU_RLC: begin
            res = {a[6:0], cin};
            nf[isq_pkg::FLAG_C] = a[7];
         end
         isq_pkg::ALU_INC: begin
            res = a + 8'h01;
         end
         isq_pkg::ALU_DEC: begin
            res = a - 8'h01;
         end
         default: begin
            res = a;
         end
      endcase
      // rotations leave the zero flag alone
      if (fn < isq_pkg::ALU_RR || fn > isq_pkg::ALU_RLC) begin
         nf[isq_pkg::FLAG_Z] = (res == 8'h00);
      end
      alu_calc = {nf, res};
   endfunction

   assign t1 = (phase == isq_pkg::ISQ_T1);
   assign t4 = (phase == isq_pkg::ISQ_T4);
   assign op_class = exec_ir[14:12];
   assign op_fn = exec_ir[11:8];
   assign op_imm = exec_ir[7:0];
   assign op_target = exec_ir[10:0];

   // (RULE1) four-phase ring
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         phase <= isq_pkg::ISQ_T1;
      end else begin
         case (phase)
            isq_pkg::ISQ_T1: phase <= isq_pkg::ISQ_T2;
            isq_pkg::ISQ_T2: phase <= isq_pkg::ISQ_T3;
            isq_pkg::ISQ_T3: phase <= isq_pkg::ISQ_T4;
            isq_pkg::ISQ_T4: phase <= isq_pkg::ISQ_T1;
            default: phase <= isq_pkg::ISQ_T1;
         endcase
      end
   end

   assign phase_out = phase;

   // (RULE2) fetch strobe only in the first phase
   assign mem_rd_out = t1 & run;
   assign mem_addr_out = pc;

   // skip conditions; the step variants also write back the stepped value
   always_comb begin
      skip_hit = 1'b0;
      step_val = acc;
      case (op_fn[1:0])
         isq_pkg::SKIP_ZERO: skip_hit = (acc == 8'h00);
         isq_pkg::SKIP_NONZERO: skip_hit = (acc != 8'h00);
         isq_pkg::SKIP_INC_ZERO: begin
            step_val = acc + 8'h01;
            skip_hit = (step_val == 8'h00);
         end
         isq_pkg::SKIP_DEC_ZERO: begin
            step_val = acc - 8'h01;
            skip_hit = (step_val == 8'h00);
         end
         default: skip_hit = 1'b0;
      endcase
   end

   // (RULE3) decode acts in the last phase of the execute cycle
   assign do_alu = t4 && (op_class == isq_pkg::OP_ALU);
   assign do_movi = t4 && (op_class == isq_pkg::OP_MOVI);
   assign do_branch = t4 && (op_class == isq_pkg::OP_BRANCH);
   assign do_call = t4 && (op_class == isq_pkg::OP_CALL);
   assign do_return = t4 && (op_class == isq_pkg::OP_RETURN);
   assign do_skip = t4 && (op_class == isq_pkg::OP_SKIP) && skip_hit;
   assign do_pcl_op = t4 && (op_class == isq_pkg::OP_PCL_WR);

   // (RULE16) no acknowledge while full or while the flow already changes
   assign irq_take = t4 && irq_pending && !stack_full && !pcl_wr
      && !(do_branch || do_call || do_return || do_skip || do_pcl_op);
   assign int_ack_out = irq_take;

   // (RULE13) call and interrupt entry both save a return address
   assign push = do_call || irq_take;

   // (RULE5) (RULE9) (RULE11) any of these discards the prefetched word
   assign flow_change = do_branch || do_call || do_return || do_skip
      || do_pcl_op || irq_take || pcl_wr;

   // kill flag: a flow change wins over the clear at the next fetch
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         kill <= 1'b0;
      end else if (flow_change) begin
         kill <= 1'b1;
      end else if (t1) begin
         kill <= 1'b0;
      end
   end

   // (RULE4) fetch into the prefetch slot while the older word executes
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         fetch_ir <= DUMMY_WORD;
         exec_ir <= DUMMY_WORD;
      end else if (t1) begin
         fetch_ir <= run ? mem_data_in : DUMMY_WORD;
         exec_ir <= kill ? DUMMY_WORD : fetch_ir;
      end
   end

   // pc points one word past the prefetch, so the return is pc minus one
   assign push_val = pc - 11'h001;

   // (RULE20) restart at the reset vector
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         pc <= isq_pkg::RESET_PC;
      end else if (pcl_wr) begin
         // (RULE10) bus write keeps the page bits
         pc <= page_jump(pc, wb_dat_in[7:0]);
      end else if (do_branch || do_call) begin
         // (RULE8) direct load of the target
         pc <= op_target;
      end else if (do_return) begin
         // (RULE14) restore from the stack
         pc <= stack_top;
      end else if (irq_take) begin
         pc <= isq_pkg::IRQ_VECTOR;
      end else if (do_pcl_op) begin
         pc <= page_jump(pc, acc);
      end else if (t1 && run) begin
         // (RULE6) plain step of one
         pc <= pc + 11'h001;
      end
   end

   // (RULE21) full and empty follow from the depth parameter
   assign stack_full = (cnt == CNT_FULL);
   assign stack_empty = (cnt == '0);
   assign stack_full_out = stack_full;
   assign sp_below = (sp == '0) ? PTR_LAST : sp - SP_W'(1);
   assign stack_top = stack_mem[sp_below];

   // (RULE12) stack storage has no path to the register port
   always_ff @(posedge clock_in) begin
      if (push) begin
         stack_mem[sp] <= push_val;
      end
   end

   // (RULE15) reset empties the stack
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         sp <= '0;
         cnt <= '0;
      end else if (push) begin
         // (RULE17) wrap overwrites the oldest entry when full
         sp <= (sp == PTR_LAST) ? '0 : sp + SP_W'(1);
         if (!stack_full) begin
            cnt <= cnt + CNT_W'(1);
         end
      end else if (do_return && !stack_empty) begin
         sp <= sp_below;
         cnt <= cnt - CNT_W'(1);
      end
   end

   // request latch; a new request wins over the clear on acceptance
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         irq_pending <= 1'b0;
      end else if (irq_in) begin
         irq_pending <= 1'b1;
      end else if (irq_take) begin
         irq_pending <= 1'b0;
      end
   end

   // (RULE18) (RULE19) result and flags land in the last phase
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         acc <= isq_pkg::ACC_RESET;
         flags <= isq_pkg::FLAGS_RESET;
      end else if (do_alu) begin
         {flags, acc} <= alu_calc(op_fn, acc, op_imm, flags);
      end else if (do_movi) begin
         acc <= op_imm;
      end else if (t4 && (op_class == isq_pkg::OP_SKIP) && op_fn[1]) begin
         acc <= step_val;
      end
   end

   // register port: write lands on the edge that sees ack high
   assign bus_req = wb_cyc_in & wb_stb_in;
   assign bus_wr = bus_req & wb_we_in & wb_ack_out & wb_sel_in[0];
   assign pcl_wr = bus_wr && (wb_adr_in == isq_pkg::REG_PC_LOW_BYTE);
   assign ctl_wr = bus_wr && (wb_adr_in == isq_pkg::REG_CONTROL);

   // (RULE7) only the low counter byte is visible to software
   always_comb begin
      case (wb_adr_in)
         isq_pkg::REG_PC_LOW_BYTE: rd_mux = {24'h000000, pc[7:0]};
         isq_pkg::REG_STATUS: rd_mux = {16'h0000, acc, 4'h0, flags};
         isq_pkg::REG_CONTROL: rd_mux = {31'h00000000, run};
         default: rd_mux = 32'h00000000;
      endcase
   end

   // one wait state, ack stands for a single cycle
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h00000000;
      end else begin
         wb_ack_out <= bus_req & ~wb_ack_out;
         if (bus_req & ~wb_ack_out) begin
            wb_dat_out <= rd_mux;
         end
      end
   end

   // run bit: cleared, fetches become dummy words and pc holds
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         run <= isq_pkg::RUN_RESET;
      end else if (ctl_wr) begin
         run <= wb_dat_in[0];
      end
   end

   // interrupt enable is assumed to be resolved before irq_in
   // a dummy word decodes as no operation, so flushed slots are inert
   // the stack is not reset, only its pointer and fill count
   // pc reads back the fetch pointer, not the executing address

endmodule

// ### logic/isq_pkg.sv
// constants, types and register map of the instruction sequencer
// assumes a single 200 MHz clock and a classic wishbone register port
package isq_pkg;
   localparam int PC_W = 11;
   localparam int IW_W = 15;
   localparam int DW = 8;
   localparam logic [10:0] RESET_PC = 11'h000;
   localparam logic [10:0] IRQ_VECTOR = 11'h004;
   // four internal phases, one instruction cycle
   typedef enum logic [3:0] {
      ISQ_T1 = 4'b0001,
      ISQ_T2 = 4'b0010,
      ISQ_T3 = 4'b0100,
      ISQ_T4 = 4'b1000
   } isq_phase_t;
   // instruction word: [14:12] class, [11:8] function, [7:0] or [10:0] operand
   localparam logic [2:0] OP_NOP = 3'h0;
   localparam logic [2:0] OP_ALU = 3'h1;
   localparam logic [2:0] OP_BRANCH = 3'h2;
   localparam logic [2:0] OP_CALL = 3'h3;
   localparam logic [2:0] OP_RETURN = 3'h4;
   localparam logic [2:0] OP_SKIP = 3'h5;
   localparam logic [2:0] OP_PCL_WR = 3'h6;
   localparam logic [2:0] OP_MOVI = 3'h7;
   localparam logic [3:0] ALU_ADD = 4'h0;
   localparam logic [3:0] ALU_ADC = 4'h1;
   localparam logic [3:0] ALU_SUB = 4'h2;
   localparam logic [3:0] ALU_SBC = 4'h3;
   localparam logic [3:0] ALU_DADJ = 4'h4;
   localparam logic [3:0] ALU_AND = 4'h5;
   localparam logic [3:0] ALU_OR = 4'h6;
   localparam logic [3:0] ALU_XOR = 4'h7;
   localparam logic [3:0] ALU_CPL = 4'h8;
   localparam logic [3:0] ALU_RR = 4'h9;
   localparam logic [3:0] ALU_RRC = 4'ha;
   localparam logic [3:0] ALU_RL = 4'hb;
   localparam logic [3:0] ALU_RLC = 4'hc;
   localparam logic [3:0] ALU_INC = 4'hd;
   localparam logic [3:0] ALU_DEC = 4'he;
   localparam logic [1:0] SKIP_ZERO = 2'h0;
   localparam logic [1:0] SKIP_NONZERO = 2'h1;
   localparam logic [1:0] SKIP_INC_ZERO = 2'h2;
   localparam logic [1:0] SKIP_DEC_ZERO = 2'h3;
   // status flag positions
   localparam int FLAG_C = 0;
   localparam int FLAG_AC = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_OV = 3;
   // register byte offsets
   localparam logic [7:0] REG_PC_LOW_BYTE = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_PC = 8'h08;
   localparam logic [7:0] REG_CONTROL = 8'h0c;
   localparam logic RUN_RESET = 1'b1;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [3:0] FLAGS_RESET = 4'h0;
endpackage

// ### testbench/isq_chk.sv
// port checker for the sequencer core
// assumes one clock and a synchronous active-low reset
`timescale 1ns/100ps
module isq_chk (input wire logic clock_in, input wire logic rst_n_in,
   input wire logic wb_cyc_in, input wire logic wb_stb_in, input wire logic wb_ack_out,
   input wire logic mem_rd_out, input wire logic [10:0] mem_addr_out,
   input wire logic int_ack_out, input wire logic [3:0] phase_out,
   input wire logic stack_full_out);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_t4; phase_out == 4'b1000; endsequence
   sequence s_t1; phase_out == 4'b0001; endsequence
   a_phase_onehot: assert property ($onehot(phase_out)) else $error("phase");
   a_phase_wrap: assert property (s_t4 |=> s_t1) else $error("wrap");
   a_phase_step: assert property (!s_t4 |=> phase_out == $past(phase_out) << 1)
      else $error("step");
   a_fetch_first: assert property (mem_rd_out |-> s_t1) else $error("fetch");
   a_ack_single: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack");
   a_ack_cause: assert property (wb_ack_out |-> wb_cyc_in && wb_stb_in) else $error("req");
   a_full_noack: assert property (stack_full_out |-> !int_ack_out) else $error("full");
   a_reset_zero: assert property ($rose(rst_n_in) |-> ##[0:8] mem_rd_out && mem_addr_out == 0)
      else $error("start");
endmodule
bind isq_core isq_chk u_chk (.*);

// ### testbench/isq_mem.sv
// program memory model, unlisted words no-operation
// assumes the fetch strobe qualifies the address
`timescale 1ns/100ps
module isq_mem (input wire logic rd_in, input wire logic [10:0] addr_in,
   output logic [14:0] data_out);
   logic [14:0] word;
   // branch, call, return, then a skip that hides the load at 063
   always_comb begin
      case (addr_in)
         11'h040: word = 15'h2060;
         11'h060: word = 15'h3070;
         11'h061: word = 15'h7000;
         11'h062: word = 15'h5000;
         11'h063: word = 15'h7055;
         11'h064: word = 15'h1001;
         11'h070: word = 15'h4000;
         default: word = 15'h0000;
      endcase
   end
   // unread cycles show all ones so stale data is not trusted
   assign data_out = rd_in ? word : 15'h7fff;
endmodule

// ### testbench/test_instruction_sequencer_pc_stack.sv
// bench: fetch order after reset and low byte page jump
// assumes the core, the memory model and the bound checker
`timescale 1ns/100ps
module test_instruction_sequencer_pc_stack;
   logic clock_in = 0, rst_n_in = 0, cyc = 0, we = 0, irq = 0, ack, rd, iack, full;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, dout;
   logic [10:0] maddr;
   logic [14:0] mdat;
   logic [3:0] ph;
   int miscompares = 0, comparisons = 0, cycles = 0;
   initial forever #2.5 clock_in = ~clock_in;
   isq_core DUT (.clock_in, .rst_n_in, .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we),
      .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wdat), .wb_dat_out(dout), .wb_ack_out(ack),
      .mem_addr_out(maddr), .mem_rd_out(rd), .mem_data_in(mdat), .irq_in(irq),
      .int_ack_out(iack), .phase_out(ph), .stack_full_out(full));
   isq_mem u_mem (.rd_in(rd), .addr_in(maddr), .data_out(mdat));
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_in) begin cyc <= 1; we <= w; adr <= a; wdat <= d; end
      do @(posedge clock_in); while (ack !== 1'b1);
      rdat = dout;
      cyc <= 0;
   endtask
   task automatic fetch(input logic [10:0] a, input logic seek);
      int n = 0;
      do @(posedge clock_in); while ((rd !== 1'b1 || (seek && maddr !== a)) && ++n < 40);
      chk("fetch address", {21'h0, maddr}, {21'h0, a});
   endtask
   task automatic summarize;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clock_in) if (++cycles == 3000) begin miscompares++; summarize(); end
   initial begin
      repeat (6) @(posedge clock_in);
      rst_n_in <= 1;
      fetch(11'h000, 0);
      fetch(11'h001, 0);
      wb(1, isq_pkg::REG_PC_LOW_BYTE, 32'h40);
      fetch(11'h040, 1);
      fetch(11'h041, 0);
      fetch(11'h060, 0);
      fetch(11'h061, 0);
      fetch(11'h070, 0);
      fetch(11'h071, 0);
      fetch(11'h061, 0);
      fetch(11'h066, 1);
      wb(0, isq_pkg::REG_STATUS, 0);
      chk("alu status", rdat, 32'h00000100);
      wb(0, 8'hfc, 0);
      chk("stack full", {31'h0, full}, 0);
      @(posedge clock_in) irq <= 1;
      @(posedge clock_in) irq <= 0;
      fetch(isq_pkg::IRQ_VECTOR, 1);
      summarize();
   end
endmodule
